/* File: logic/chis_pkg.sv */
/*
 * constants of the card host raw event status block: register offsets,
 * bit positions, reset values and widths.
 * assumes a 32-bit avalon-mm slave with byte addresses.
 */
package chis_pkg;
    // ==========================================================
    // widths
    localparam int unsigned DATA_W = 32;  // bus data width
    localparam int unsigned ADDR_W = 4;   // byte address width
    localparam int unsigned FLAG_W = 18;  // clearable sticky flags
    localparam int unsigned SRC_W = 19;   // maskable sources
    // ==========================================================
    // register offsets
    localparam logic [3:0] OFS_STATUS = 4'h0;  // raw event status, ro
    localparam logic [3:0] OFS_MASK = 4'h4;    // source mask, rw
    localparam logic [3:0] OFS_CLEAR = 4'h8;   // flag clear, wo
    // ==========================================================
    // bit positions
    localparam int unsigned BIT_LINE3 = 19;       // live line 3 level
    localparam int unsigned BIT_SDIO = 18;        // card interrupt
    localparam int unsigned BIT_DATA_DONE = 17;   // data transfer done
    localparam int unsigned BIT_DATA_CRC = 16;    // data check failed
    localparam int unsigned BIT_REPLY = 15;       // reply captured
    localparam int unsigned BIT_REPLY_CRC = 14;   // reply check failed
    localparam int unsigned BIT_IDLE_LOW = 13;    // idle, line 3 low
    localparam int unsigned BIT_IDLE_HIGH = 12;   // idle, line 3 high
    localparam int unsigned BIT_CMD_SENT = 11;    // command sent
    localparam int unsigned BIT_BUSY_END = 10;    // card busy ended
    localparam int unsigned BIT_TX_POP = 9;       // tx fifo card-side error
    localparam int unsigned BIT_RX_PUSH = 8;      // rx fifo card-side error
    localparam int unsigned BIT_DMA_POP = 7;      // rx fifo bus-side error
    localparam int unsigned BIT_DMA_PUSH = 6;     // tx fifo bus-side error
    // ==========================================================
    // reset values
    localparam logic [31:0] STATUS_RST = 32'h00000000;
    localparam logic [18:0] MASK_RST = 19'h7FFFF;
    localparam logic [17:0] FLAG_RST = 18'h00000;
    localparam logic [31:0] RDATA_RST = 32'h00000000;
endpackage : chis_pkg

/* File: logic/chis_evt_if.sv */
/*
 * bundle between the status controller, its sticky flag bank and its
 * line 3 tracker.
 * assumes all three parties run on the one block clock.
 */
`timescale 1ns/10ps
`default_nettype none
interface chis_evt_if;
    logic [17:0] set_vec;    // one-cycle set requests
    logic [17:0] clr_vec;    // one-cycle clear requests
    logic [17:0] flags;      // sticky flag state
    logic line3_level;       // registered line 3 level
    logic idle_low_set;      // idle while line 3 low
    logic idle_high_set;     // idle while line 3 high
    modport ctrl (output set_vec, output clr_vec, input flags,
                  input line3_level, input idle_low_set, input idle_high_set);
    modport bank (input set_vec, input clr_vec, output flags);
    modport track (output line3_level, output idle_low_set, output idle_high_set);
endinterface : chis_evt_if
`default_nettype wire

/* File: logic/chis_flag_bank.sv */
/*
 * sticky raw event flags: set requests win over clear requests.
 * assumes set and clear vectors are one-cycle requests on mclk_i.
 */
`timescale 1ns/10ps
`default_nettype none
module chis_flag_bank (
    input wire logic mclk_i,       // block clock
    input wire logic nrst_i,       // sync reset, active low
    chis_evt_if.bank ev            // flag bundle
);
    // ==========================================================
    // flag storage
    logic [17:0] flags_reg;   // sticky flags
    logic [17:0] flags_next;  // next flag state

    // a set in the same cycle as a clear is kept, so no event is lost
    always_comb
    begin
        flags_next = (flags_reg & ~ev.clr_vec) | ev.set_vec;
    end

    // flags start cleared
    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i)
        begin
            flags_reg <= chis_pkg::FLAG_RST;
        end
        else
        begin
            flags_reg <= flags_next;
        end
    end

    assign ev.flags = flags_reg;

    // ==========================================================
    // checks
    property p_set_wins;
        @(posedge mclk_i) disable iff (!nrst_i)
        (|ev.set_vec) |=> ((flags_reg & $past(ev.set_vec)) == $past(ev.set_vec));
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("set lost to clear");

    property p_clr_only;
        @(posedge mclk_i) disable iff (!nrst_i)
        (|(ev.clr_vec & ~ev.set_vec)) |=> ((flags_reg & $past(ev.clr_vec & ~ev.set_vec)) == 18'h00000);
    endproperty
    a_clr_only: assert property (p_clr_only) else $error("flag not cleared");
endmodule : chis_flag_bank
`default_nettype wire

/* File: logic/chis_line3_track.sv */
/*
 * line 3 level capture and idle-level event generation.
 * assumes the pin and the idle level are synchronous to mclk_i.
 */
`timescale 1ns/10ps
`default_nettype none
module chis_line3_track (
    input wire logic mclk_i,           // block clock
    input wire logic nrst_i,           // sync reset, active low
    input wire logic card_line3_pin_i, // card data line 3
    input wire logic data_idle_i,      // data engine idle
    chis_evt_if.track ev               // tracker bundle
);
    // ==========================================================
    // level capture
    logic line3_level_reg;  // one-cycle copy of the pin

    // keeps following the pin; it is never latched by an event
    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i)
        begin
            line3_level_reg <= 1'b0;
        end
        else
        begin
            line3_level_reg <= card_line3_pin_i;
        end
    end

    assign ev.line3_level = line3_level_reg;
    // requests repeat every cycle the condition holds, so a clear
    // while the card still sits there is immediately undone
    assign ev.idle_low_set = data_idle_i & ~line3_level_reg;
    assign ev.idle_high_set = data_idle_i & line3_level_reg;
endmodule : chis_line3_track
`default_nettype wire

/* File: logic/chis_status_ctrl.sv */
/*
 * raw event status controller of a memory-card host: gathers event
 * pulses into sticky flags, shows them unmasked on a read-only word,
 * masks them onto one level interrupt and clears them by write.
 * assumes an avalon-mm master with waitrequest on mclk_i and event
 * inputs that are one-cycle pulses synchronous to mclk_i.
 */
`timescale 1ns/10ps
`default_nettype none
module chis_status_ctrl (
    input wire logic mclk_i,                // block clock, 100 MHz
    input wire logic nrst_i,                // sync reset, active low
    // ==========================================================
    // avalon-mm slave
    input wire logic [3:0] avs_address_i,   // byte address
    input wire logic avs_read_i,            // read request
    input wire logic avs_write_i,           // write request
    input wire logic [31:0] avs_writedata_i,// write data
    input wire logic [3:0] avs_byteenable_i,// byte lanes
    output logic [31:0] avs_readdata_o,     // read data
    output logic avs_waitrequest_o,         // stall, high by default
    output logic irq_o,                     // level interrupt
    // ==========================================================
    // event sources
    input wire logic data_done_i,           // transfer finished
    input wire logic data_crc_err_i,        // data check mismatch
    input wire logic reply_ready_i,         // reply captured
    input wire logic reply_crc_err_i,       // reply check failed
    input wire logic cmd_sent_i,            // command sent
    input wire logic busy_end_i,            // card busy ended
    input wire logic tx_pop_err_i,          // tx fifo card-side error
    input wire logic rx_push_err_i,         // rx fifo card-side error
    input wire logic dma_pop_err_i,         // rx fifo bus-side error
    input wire logic dma_push_err_i,        // tx fifo bus-side error
    input wire logic [5:0] fifo_evt_i,      // fifo level events
    input wire logic sdio_card_irq_i,       // card interrupt level
    input wire logic data_idle_i,           // data engine idle
    input wire logic card_line3_pin_i       // card data line 3
);
    // ==========================================================
    // bus handshake states
    typedef enum logic [0:0] {
        CHIS_BUS_IDLE = 1'b0,   // waiting for a request
        CHIS_BUS_ACK = 1'b1     // waitrequest low, request taken
    } chis_bus_t;

    chis_bus_t bus_reg;              // handshake state
    chis_bus_t bus_next;             // next handshake state
    logic waitreq_reg;               // waitrequest flop
    logic [31:0] rdata_reg;          // read data flop
    logic [18:0] mask_reg;           // source mask
    logic sdio_reg;                  // registered card interrupt
    logic irq_reg;                   // interrupt flop
    logic [31:0] status_word;        // assembled raw word
    logic [31:0] rd_word;            // decoded read value
    logic take;                      // request taken this edge
    logic wr_mask;                   // mask write taken
    logic wr_clear;                  // clear write taken
    logic [31:0] lanes;              // byte enables as bit mask

    chis_evt_if ev ();               // bundle to the sub-blocks

    // ==========================================================
    // byte lanes to bit mask, used for mask and clear writes
    function automatic logic [31:0] be_bits(input logic [3:0] be);
        be_bits = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : be_bits

    // ==========================================================
    // sub-blocks
    chis_flag_bank u_bank (
        .mclk_i (mclk_i),
        .nrst_i (nrst_i),
        .ev     (ev)
    );

    chis_line3_track u_track (
        .mclk_i           (mclk_i),
        .nrst_i           (nrst_i),
        .card_line3_pin_i (card_line3_pin_i),
        .data_idle_i      (data_idle_i),
        .ev               (ev)
    );

    // ==========================================================
    // event gathering
    // each source sets its own flag; fifo level events ride along
    always_comb
    begin
        ev.set_vec = 18'h00000;
        ev.set_vec[chis_pkg::BIT_DATA_DONE] = data_done_i;
        ev.set_vec[chis_pkg::BIT_DATA_CRC] = data_crc_err_i;
        ev.set_vec[chis_pkg::BIT_REPLY] = reply_ready_i;
        ev.set_vec[chis_pkg::BIT_REPLY_CRC] = reply_crc_err_i;
        ev.set_vec[chis_pkg::BIT_IDLE_LOW] = ev.idle_low_set;
        ev.set_vec[chis_pkg::BIT_IDLE_HIGH] = ev.idle_high_set;
        ev.set_vec[chis_pkg::BIT_CMD_SENT] = cmd_sent_i;
        ev.set_vec[chis_pkg::BIT_BUSY_END] = busy_end_i;
        ev.set_vec[chis_pkg::BIT_TX_POP] = tx_pop_err_i;
        ev.set_vec[chis_pkg::BIT_RX_PUSH] = rx_push_err_i;
        ev.set_vec[chis_pkg::BIT_DMA_POP] = dma_pop_err_i;
        ev.set_vec[chis_pkg::BIT_DMA_PUSH] = dma_push_err_i;
        ev.set_vec[5:0] = fifo_evt_i;
    end

    // card interrupt is a level owned by the card; only servicing
    // the card drops it, so it has no clear path here
    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i)
        begin
            sdio_reg <= 1'b0;
        end
        else
        begin
            sdio_reg <= sdio_card_irq_i;
        end
    end

    // raw word: no mask applied, reserved bits tied low
    always_comb
    begin
        status_word = chis_pkg::STATUS_RST;
        status_word[17:0] = ev.flags;
        status_word[chis_pkg::BIT_SDIO] = sdio_reg;
        status_word[chis_pkg::BIT_LINE3] = ev.line3_level;
    end

    // ==========================================================
    // bus handshake
    // request seen while idle: drop waitrequest for one cycle;
    // the master's request is taken at the end of that cycle
    always_comb
    begin
        bus_next = bus_reg;
        case (bus_reg)
            CHIS_BUS_IDLE:
            begin
                if (avs_read_i || avs_write_i)
                begin
                    bus_next = CHIS_BUS_ACK;
                end
            end
            CHIS_BUS_ACK:
            begin
                bus_next = CHIS_BUS_IDLE;
            end
            default:
            begin
                bus_next = CHIS_BUS_IDLE;
            end
        endcase
    end

    // state and waitrequest flop together
    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i)
        begin
            bus_reg <= CHIS_BUS_IDLE;
            waitreq_reg <= 1'b1;
        end
        else
        begin
            bus_reg <= bus_next;
            waitreq_reg <= (bus_next != CHIS_BUS_ACK);
        end
    end

    assign take = (bus_reg == CHIS_BUS_ACK);
    assign lanes = be_bits(avs_byteenable_i);
    assign wr_mask = take && avs_write_i && (avs_address_i == chis_pkg::OFS_MASK);
    assign wr_clear = take && avs_write_i && (avs_address_i == chis_pkg::OFS_CLEAR);

    // ==========================================================
    // read decode
    // unmapped and write-only offsets read as zero
    always_comb
    begin
        if (avs_address_i == chis_pkg::OFS_STATUS)
        begin
            rd_word = status_word;
        end
        else if (avs_address_i == chis_pkg::OFS_MASK)
        begin
            rd_word = {13'h0, mask_reg};
        end
        else
        begin
            rd_word = chis_pkg::RDATA_RST;
        end
    end

    // read data is a snapshot taken as waitrequest drops
    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i)
        begin
            rdata_reg <= chis_pkg::RDATA_RST;
        end
        else if (bus_reg == CHIS_BUS_IDLE && avs_read_i)
        begin
            rdata_reg <= rd_word;
        end
    end

    // ==========================================================
    // mask register
    // writes to the status offset land nowhere, so it stays read-only
    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i)
        begin
            mask_reg <= chis_pkg::MASK_RST;
        end
        else if (wr_mask)
        begin
            mask_reg <= (mask_reg & ~lanes[18:0]) | (avs_writedata_i[18:0] & lanes[18:0]);
        end
    end

    // ==========================================================
    // clear register
    // only the clearable flags; bit 18 and 19 are not reachable here
    always_comb
    begin
        ev.clr_vec = 18'h00000;
        if (wr_clear)
        begin
            ev.clr_vec = avs_writedata_i[17:0] & lanes[17:0];
        end
    end

    // ==========================================================
    // interrupt
    // registered for a clean pin; trails the flags by one cycle
    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i)
        begin
            irq_reg <= 1'b0;
        end
        else
        begin
            irq_reg <= |(status_word[18:0] & ~mask_reg);
        end
    end

    assign avs_readdata_o = rdata_reg;
    assign avs_waitrequest_o = waitreq_reg;
    assign irq_o = irq_reg;

    // ==========================================================
    // checks
    property p_raw_read;
        @(posedge mclk_i) disable iff (!nrst_i)
        (bus_reg == CHIS_BUS_IDLE && avs_read_i && avs_address_i == chis_pkg::OFS_STATUS)
        |=> (avs_readdata_o == $past(status_word));
    endproperty
    a_raw_read: assert property (p_raw_read) else $error("status read not raw");

    property p_line3;
        @(posedge mclk_i) disable iff (!nrst_i)
        ##1 (status_word[19] == $past(card_line3_pin_i));
    endproperty
    a_line3: assert property (p_line3) else $error("bit 19 not line 3");

    property p_sdio_keep;
        @(posedge mclk_i) disable iff (!nrst_i)
        (sdio_card_irq_i && wr_clear && avs_writedata_i[18]) |=> status_word[18];
    endproperty
    a_sdio_keep: assert property (p_sdio_keep) else $error("card irq cleared");

    property p_done;
        @(posedge mclk_i) disable iff (!nrst_i)
        data_done_i |=> status_word[17];
    endproperty
    a_done: assert property (p_done) else $error("done flag missing");

    property p_reply;
        @(posedge mclk_i) disable iff (!nrst_i)
        (reply_ready_i |=> status_word[15]) and (reply_crc_err_i |=> status_word[14]);
    endproperty
    a_reply: assert property (p_reply) else $error("reply flags missing");

    property p_idle_low;
        @(posedge mclk_i) disable iff (!nrst_i)
        (data_idle_i && !card_line3_pin_i) ##1 data_idle_i |=> status_word[13];
    endproperty
    a_idle_low: assert property (p_idle_low) else $error("idle low flag missing");

    property p_idle_high;
        @(posedge mclk_i) disable iff (!nrst_i)
        (data_idle_i && card_line3_pin_i) ##1 data_idle_i |=> status_word[12];
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("idle high flag missing");

    property p_reserved;
        @(posedge mclk_i) disable iff (!nrst_i)
        avs_readdata_o[31:20] == 12'h000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits set");

    property p_mask_rst;
        @(posedge mclk_i) disable iff (!nrst_i)
        $past(!nrst_i) |-> (mask_reg == chis_pkg::MASK_RST && status_word == chis_pkg::STATUS_RST);
    endproperty
    a_mask_rst: assert property (p_mask_rst) else $error("bad reset values");

    property p_clear17;
        @(posedge mclk_i) disable iff (!nrst_i)
        (wr_clear && avs_byteenable_i[2] && avs_writedata_i[17] && !data_done_i) |=> !status_word[17];
    endproperty
    a_clear17: assert property (p_clear17) else $error("clear ignored");

    property p_irq;
        @(posedge mclk_i) disable iff (!nrst_i)
        (|(status_word[18:0] & ~mask_reg)) [*2] |-> irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("irq not raised");

    property p_irq_low;
        @(posedge mclk_i) disable iff (!nrst_i)
        (!(|(status_word[18:0] & ~mask_reg))) [*2] |-> !irq_o;
    endproperty
    a_irq_low: assert property (p_irq_low) else $error("irq stuck high");

    property p_answer;
        @(posedge mclk_i) disable iff (!nrst_i)
        ((avs_read_i || avs_write_i) && avs_waitrequest_o) |-> ##[0:1] !avs_waitrequest_o;
    endproperty
    a_answer: assert property (p_answer) else $error("no bus answer");

    c_read: cover property (@(posedge mclk_i) disable iff (!nrst_i)
        take && avs_read_i && avs_address_i == chis_pkg::OFS_STATUS);
    c_clear: cover property (@(posedge mclk_i) disable iff (!nrst_i)
        wr_clear && (|(ev.clr_vec & ev.flags)));
    c_irq: cover property (@(posedge mclk_i) disable iff (!nrst_i) $rose(irq_o));
endmodule : chis_status_ctrl
`default_nettype wire

/* File: verif/chis_card_model.sv */
/*
 * card-side model: drives card data line 3 and holds the card interrupt.
 * assumes the bench commands it on the rising edge of mclk_i.
 */
`timescale 1ns/10ps
`default_nettype none
module chis_card_model (
    input wire logic mclk_i,         // block clock
    input wire logic line3_drive_i,  // wanted line 3 level
    input wire logic irq_raise_i,    // card raises its interrupt
    input wire logic irq_service_i,  // host services the card
    output logic card_line3_pin_o,   // card data line 3
    output logic sdio_card_irq_o     // card interrupt level
);
    // ==========================================================
    // line 3 follows the wanted level one edge late, like a real pad
    // plain always, since the initial block also writes the pin
    initial card_line3_pin_o = 1'b0;
    always @(posedge mclk_i)
    begin
        card_line3_pin_o <= line3_drive_i;
    end
    // ==========================================================
    // interrupt stays up until serviced; a host clear cannot drop it
    initial sdio_card_irq_o = 1'b0;
    always @(posedge mclk_i)
    begin
        if (irq_service_i)
        begin
            sdio_card_irq_o <= 1'b0;
        end
        else if (irq_raise_i)
        begin
            sdio_card_irq_o <= 1'b1;
        end
    end
endmodule : chis_card_model
`default_nettype wire

/* File: verif/tb_top.sv */
/*
 * self-checking bench of the raw event status block over avalon-mm.
 * assumes chis_pkg, the design files and the card model compile first.
 */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin bad_count++; \
    $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module tb_top;
    // ==========================================================
    // stimulus and observed signals
    logic mclk_i = 1'b0, nrst_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
    logic data_idle_i = 1'b0, line3_cmd = 1'b0, irq_raise = 1'b0, irq_service = 1'b0;
    logic [3:0] avs_address_i = 4'h0;
    logic [31:0] avs_writedata_i = 32'h00000000;
    logic [17:0] evt = 18'h00000; // event pulses, bits 13..12 unused
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o, irq_o, pin, card_irq;
    int bad_count = 0;
    int checks = 0;
    chis_status_ctrl uut (.mclk_i(mclk_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .irq_o(irq_o), .data_done_i(evt[17]), .data_crc_err_i(evt[16]), .reply_ready_i(evt[15]),
        .reply_crc_err_i(evt[14]), .cmd_sent_i(evt[11]), .busy_end_i(evt[10]), .tx_pop_err_i(evt[9]),
        .rx_push_err_i(evt[8]), .dma_pop_err_i(evt[7]), .dma_push_err_i(evt[6]), .fifo_evt_i(evt[5:0]),
        .sdio_card_irq_i(card_irq), .data_idle_i(data_idle_i), .card_line3_pin_i(pin));
    chis_card_model card (.mclk_i(mclk_i), .line3_drive_i(line3_cmd), .irq_raise_i(irq_raise),
        .irq_service_i(irq_service), .card_line3_pin_o(pin), .sdio_card_irq_o(card_irq));
    // ==========================================================
    // clock and watchdog; a hang counts as a mismatch
    initial forever #5 mclk_i = ~mclk_i;
    initial
    begin
        #100000;
        bad_count++;
        stop_test();
    end
    // ==========================================================
    // one bus access; the request stands until waitrequest is sampled low at a
    // rising edge, data is taken at that edge, only the watchdog ends a hang
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge mclk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= ~wr;
        @(posedge mclk_i);
        while (avs_waitrequest_o !== 1'b0)
        begin
            @(posedge mclk_i);
        end
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask : bus
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h00000000, q);
        `CHK(q, e)
    endtask : rdchk
    task automatic pulse(input int b);
        @(posedge mclk_i);
        evt <= 18'h00001 << b;
        @(posedge mclk_i);
        evt <= 18'h00000;
    endtask : pulse
    task automatic stop_test();
        if (bad_count == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : stop_test
    // ==========================================================
    // main sequence
    initial
    begin
        repeat (10) @(posedge mclk_i);
        nrst_i <= 1'b1;
        rdchk(chis_pkg::OFS_STATUS, 32'h00000000);
        rdchk(chis_pkg::OFS_MASK, 32'h0007FFFF);
        rdchk(4'hC, 32'h00000000);
        // every event flag but bits 13 and 12: raw while masked, clear by 1 only
        for (int b = 0; b < 18; b++)
        begin
            if (b != 12 && b != 13)
            begin
                pulse(b);
                rdchk(chis_pkg::OFS_STATUS, 32'h1 << b);
                `CHK(irq_o, 1'b0)
                wr(chis_pkg::OFS_CLEAR, 32'h00000000);
                rdchk(chis_pkg::OFS_STATUS, 32'h1 << b);
                wr(chis_pkg::OFS_CLEAR, 32'h1 << b);
                rdchk(chis_pkg::OFS_STATUS, 32'h00000000);
            end
        end
        // status ignores writes; unmasked flag drives the interrupt
        wr(chis_pkg::OFS_STATUS, 32'hFFFFFFFF);
        rdchk(chis_pkg::OFS_STATUS, 32'h00000000);
        wr(chis_pkg::OFS_MASK, 32'h0005FFFF);
        pulse(17);
        repeat (2) @(posedge mclk_i);
        `CHK(irq_o, 1'b1)
        wr(chis_pkg::OFS_MASK, 32'h0007FFFF);
        repeat (2) @(posedge mclk_i);
        `CHK(irq_o, 1'b0)
        wr(chis_pkg::OFS_CLEAR, 32'h00020000);
        // line 3 mirror and idle-level events
        line3_cmd <= 1'b1;
        repeat (3) @(posedge mclk_i);
        rdchk(chis_pkg::OFS_STATUS, 32'h00080000);
        data_idle_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        data_idle_i <= 1'b0;
        rdchk(chis_pkg::OFS_STATUS, 32'h00081000);
        line3_cmd <= 1'b0;
        data_idle_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        data_idle_i <= 1'b0;
        wr(chis_pkg::OFS_CLEAR, 32'h00001000);
        rdchk(chis_pkg::OFS_STATUS, 32'h00002000);
        wr(chis_pkg::OFS_CLEAR, 32'h00002000);
        // card interrupt survives a clear and leaves once serviced
        irq_raise <= 1'b1;
        wr(chis_pkg::OFS_CLEAR, 32'h00040000);
        irq_raise <= 1'b0;
        rdchk(chis_pkg::OFS_STATUS, 32'h00040000);
        `CHK(irq_o, 1'b0)
        wr(chis_pkg::OFS_MASK, 32'h0003FFFF);
        repeat (2) @(posedge mclk_i);
        `CHK(irq_o, 1'b1)
        irq_service <= 1'b1;
        @(posedge mclk_i);
        irq_service <= 1'b0;
        repeat (3) @(posedge mclk_i);
        `CHK(irq_o, 1'b0)
        rdchk(chis_pkg::OFS_STATUS, 32'h00000000);
        // reset in mid-run restores status and mask
        wr(chis_pkg::OFS_MASK, 32'h00000000);
        pulse(6);
        repeat (2) @(posedge mclk_i);
        `CHK(irq_o, 1'b1)
        nrst_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        `CHK(irq_o, 1'b0)
        `CHK(avs_waitrequest_o, 1'b1)
        nrst_i <= 1'b1;
        rdchk(chis_pkg::OFS_STATUS, 32'h00000000);
        rdchk(chis_pkg::OFS_MASK, 32'h0007FFFF);
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
